// ===== tb/acs_analog_model.sv
`timescale 1ns/1ps
// ************************************************************
// Analog input channel facing the sequencer
// ************************************************************
module acs_analog_model (
  input wire logic pclk,
  input wire logic [1:0] channel_select,
  input wire logic converter_powered,
  input wire logic [9:0] level,
  output logic [9:0] sample_data
);
  logic [9:0] last_q;

  // Remember what a powered converter last saw on the selected channel.
  always_ff @(posedge pclk) begin
    if (converter_powered) begin
      last_q <= level ^ {8'h00, channel_select};
    end
  end

  // The channel number is folded in so a wrong channel shows up.
  // Unpowered, the inverse stands so a stale sample never passes.
  assign sample_data = converter_powered ?
    (level ^ {8'h00, channel_select}) : ~last_q;
endmodule // acs_analog_model

// ===== tb/adc_conversion_sequencer_tb.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_tb;
  import acs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, sleep_mode, trig, err;
  logic pready, pslverr, acquire, powered, t1r, wake, irq;
  logic [4:0] paddr;
  logic [31:0] pwdata, prdata, rd, lfsr, mask_v;
  logic [1:0] chan;
  logic [9:0] sample, level;
  logic [5:0] cfg;
  int fails, n_tests, k, n;
  int exp_q[$];

  acs_sequencer u_acs_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_mode(sleep_mode), .special_event_trigger(trig),
    .sample_data(sample), .channel_select(chan), .acquire(acquire),
    .converter_powered(powered), .timer1_reset(t1r),
    .wake_request(wake), .irq(irq));
  acs_analog_model u_acs_analog_model (.pclk(pclk), .channel_select(chan),
    .converter_powered(powered), .level(level), .sample_data(sample));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is sampled high or 16 cycles pass.
  task automatic apb(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [9:0] nxt();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[9:0];
  endfunction

  // Reference layout of the result pair, high byte above low byte.
  function automatic int fmt(input int s, input logic left);
    if (left) return ((s >> 2) << 8) | ((s & 3) << 6);
    return ((s >> 8) << 8) | (s & 255);
  endfunction

  // Polling go is bounded so a stuck conversion cannot hang the run.
  task automatic wait_done();
    rd = 32'h2;
    for (int i = 0; i < 800 && rd[1] === 1'b1; i++) apb(1'b0, OFF_CTRL, 0);
    chk(rd & 32'h3, 32'h1);
  endtask

  task automatic results(input logic [31:0] stat);
    chk({31'h0, irq}, {31'h0, |(stat & mask_v)});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, stat);
    apb(1'b0, OFF_RES_HIGH, 32'h0);
    chk(rd, 32'(exp_q[$] >> 8));
    apb(1'b0, OFF_RES_LOW, 32'h0);
    chk(rd, 32'(exp_q[$] & 255));
  endtask

  task automatic convert(input logic [5:0] c, input int abort_at);
    logic [9:0] s;
    s = nxt();
    level <= s;
    apb(1'b1, OFF_CTRL, {26'h0, c | 6'h01});
    apb(1'b1, OFF_CTRL, {26'h0, c | 6'h03});
    if (abort_at > 0) begin
      repeat (abort_at) @(posedge pclk);
      apb(1'b1, OFF_CTRL, {26'h0, c | 6'h01});
      repeat (40) @(posedge pclk);
      chk({31'h0, acquire}, 32'h0);
      repeat (20) @(posedge pclk);
      chk({31'h0, acquire}, 32'h1);
      results(32'h2);
    end else begin
      exp_q.push_back(fmt(int'(s ^ {8'h0, c[5:4]}), c[2]));
      wait_done();
      results(32'h1);
    end
  endtask

  // RC conversion in sleep, with the done interrupt masked or not.
  task automatic rc_sleep(input logic m);
    mask_v = {31'h0, m};
    level <= nxt();
    apb(1'b1, OFF_MASK, mask_v);
    apb(1'b1, OFF_CTRL, 32'h09);
    apb(1'b1, OFF_CTRL, 32'h0B);
    sleep_mode <= 1'b1;
    exp_q.push_back(fmt(int'(level), 1'b0));
    for (n = 1; n < 1300; n++) begin
      @(posedge pclk);
      if (wake === 1'b1 || powered === 1'b0) break;
    end
    chk(32'(n > 1102 && n < 1111), 32'h1);
    chk({31'h0, wake}, {31'h0, m});
    chk({31'h0, powered}, {31'h0, m});
    sleep_mode <= 1'b0;
    wait_done();
    results(32'h1);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // The longest path is a few thousand cycles; this leaves ample margin.
  initial begin
    repeat (60000) @(posedge pclk);
    fails++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite, sleep_mode, trig} = 6'h00;
    paddr = 5'h00;
    pwdata = 32'h0;
    level = 10'h000;
    lfsr = 32'h0E6BE8F0;
    mask_v = 32'h1;
    exp_q = {0};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a <= 20; a += 4) begin
      apb(1'b0, a[4:0], 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, err}, {31'h0, a == 20});
    end
    apb(1'b1, OFF_CTRL, 32'h02);
    repeat (4) @(posedge pclk);
    chk({30'h0, powered, acquire}, 32'h0);
    apb(1'b1, OFF_MASK, mask_v);
    for (int i = 0; i < 5; i++) begin
      void'(nxt());
      cfg = {lfsr[17:16], 1'b0, i[0], 2'b00};
      convert(cfg, (i == 2) ? 100 : 0);
    end
    apb(1'b1, OFF_CTRL, 32'h03);
    repeat (30) @(posedge pclk);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({31'h0, powered}, 32'h0);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd & 32'h3, 32'h1);
    sleep_mode <= 1'b0;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h2);
    repeat (60) @(posedge pclk);
    rc_sleep(1'b1);
    rc_sleep(1'b0);
    apb(1'b1, OFF_CTRL, 32'h01);
    level <= nxt();
    repeat (60) @(posedge pclk);
    trig <= 1'b1;
    @(posedge pclk);
    trig <= 1'b0;
    exp_q.push_back(fmt(int'(level), 1'b0));
    @(posedge pclk);
    chk({31'h0, t1r}, 32'h1);
    wait_done();
    results(32'h1);
    apb(1'b1, OFF_CTRL, 32'h03);
    repeat (20) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    chk({26'h0, powered, acquire, irq, wake, t1r, pready}, 32'h0);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule // adc_conversion_sequencer_tb

// ===== verilog/acs_pkg.sv
package acs_pkg;

  // ************************************************************
  // Register map and field layout
  // ************************************************************
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_RES_HIGH = 5'h04;
  localparam logic [4:0] OFF_RES_LOW = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0C;
  localparam logic [4:0] OFF_MASK = 5'h10;
  localparam int CTRL_W = 6;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam int EVT_W = 2;
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_ABORT_BIT = 1;
  localparam logic [1:0] EVT_RESET = 2'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // ************************************************************
  // Timing, all least times rounded up to whole pclk cycles
  // ************************************************************
  localparam int CLK_NS = 40;
  localparam int TAD_SYS_NS = 1000;
  localparam int TAD_RC_NS = 4000;
  localparam int INSTR_NS = 160;
  localparam int CONV_TADS = 11;
  localparam int HOLD_TADS = 2;
  localparam int TAD_SYS_CYC = (TAD_SYS_NS + CLK_NS - 1) / CLK_NS;
  localparam int TAD_RC_CYC = (TAD_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [1:0] channel;
    logic rc_clock_select;
    logic result_justify_select;
    logic go;
    logic converter_on;
  } acs_ctrl_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } acs_result_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CONV,
    ST_HOLD
  } acs_state_t;

endpackage

// ===== verilog/acs_sequencer.sv
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module acs_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acs_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic special_event_trigger,
  input wire logic [9:0] sample_data,
  output logic [1:0] channel_select,
  output logic acquire,
  output logic converter_powered,
  output logic timer1_reset,
  output logic wake_request,
  output logic irq
);
  import acs_pkg::*;

  // Every check below runs on pclk and rests while reset is applied.
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ************************************************************
  // Helpers
  // ************************************************************
  localparam int HOLD_MAX = 200;

  // Cycles in one bit period for the selected conversion clock.
  function automatic logic [15:0] tad_cycles(input logic rc);
    tad_cycles = rc ? 16'(TAD_RC_CYC) : 16'(TAD_SYS_CYC);
  endfunction

  // Places the 10-bit sample into the result pair.
  function automatic acs_result_t justify(input logic left,
                                          input logic [9:0] s);
    justify = left ? {s, 6'h00} : {6'h00, s};
  endfunction

  acs_ctrl_t ctrl_q;
  acs_ctrl_t wctrl;
  acs_result_t res_q;
  acs_state_t state_q;
  logic [15:0] cnt_q;
  logic [9:0] samp_meta_q, samp_q;
  logic [EVT_W-1:0] status_q, mask_q;
  logic pdown_q, pready_q, pslverr_q, timer1_reset_q, wake_q;
  logic [31:0] prdata_q;
  logic wr_acc, rd_acc, wr_ctrl, busy;
  logic start_sw, start_trig, start, abort_sw, abort_sleep, abort;
  logic done;

  // ************************************************************
  // Bus decode and control events
  // ************************************************************
  // Access completes on the second access cycle, when pready is high.
  assign wr_acc = psel && penable && pwrite && pready_q;
  assign rd_acc = psel && penable && !pwrite && pready_q;
  assign wr_ctrl = wr_acc && (paddr == OFF_CTRL);
  assign wctrl = acs_ctrl_t'(pwdata[CTRL_W-1:0]);
  assign busy = (state_q == ST_DELAY) || (state_q == ST_CONV);
  // A go set in the same write that turns the converter on is ignored.
  assign start_sw = wr_ctrl && wctrl.go && wctrl.converter_on &&
                    ctrl_q.converter_on && (state_q == ST_IDLE);
  assign start_trig = special_event_trigger && ctrl_q.converter_on &&
                      (state_q == ST_IDLE);
  assign start = start_sw || start_trig;
  assign abort_sw = wr_ctrl && busy &&
                    (!wctrl.go || !wctrl.converter_on);
  assign abort_sleep = sleep_mode && busy &&
                       !ctrl_q.rc_clock_select;
  assign abort = abort_sw || abort_sleep;
  assign done = (state_q == ST_CONV) && (cnt_q == 16'h0000) && !abort;

  // ************************************************************
  // Control register
  // ************************************************************
  // Hardware go updates come last so that they take priority.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= acs_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wctrl;
        ctrl_q.go <= start_sw || (ctrl_q.go && wctrl.go &&
                                  wctrl.converter_on);
      end
      if (start_trig) begin
        ctrl_q.go <= 1'b1;
      end
      if (done || abort_sleep) begin
        ctrl_q.go <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Conversion sequencer
  // ************************************************************
  // The whole conversion is counted in pclk cycles, which keeps one
  // counter for delay, conversion and hold-off at the cost of width.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
    end else if (!ctrl_q.converter_on) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start && ctrl_q.rc_clock_select) begin
            state_q <= ST_DELAY;
            cnt_q <= 16'(INSTR_CYC - 1);
          end else if (start) begin
            state_q <= ST_CONV;
            cnt_q <= 16'(16'(CONV_TADS) * tad_cycles(1'b0) - 16'h0001);
          end
        end
        ST_DELAY, ST_CONV: begin
          if (abort) begin
            state_q <= ST_HOLD;
            cnt_q <= 16'(16'(HOLD_TADS) *
                         tad_cycles(ctrl_q.rc_clock_select) - 16'h0001);
          end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (state_q == ST_DELAY) begin
            state_q <= ST_CONV;
            cnt_q <= 16'(16'(CONV_TADS) * tad_cycles(1'b1) - 16'h0001);
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Sample capture and result registers
  // ************************************************************
  // The analog sample comes from another domain, so it is resynchronised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samp_meta_q <= 10'h000;
      samp_q <= 10'h000;
    end else begin
      samp_meta_q <= sample_data;
      samp_q <= samp_meta_q;
    end
  end

  // An aborted conversion never reaches this load.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= {RESULT_RESET, RESULT_RESET};
    end else if (done) begin
      res_q <= justify(ctrl_q.result_justify_select, samp_q);
    end
  end

  // ************************************************************
  // Power, sleep and trigger side effects
  // ************************************************************
  // Power-down leaves converter_on set; a new start powers up again.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdown_q <= 1'b0;
    end else if (abort_sleep) begin
      pdown_q <= 1'b1;
    end else if (done && sleep_mode && !mask_q[EVT_DONE_BIT]) begin
      pdown_q <= 1'b1;
    end else if (start || !ctrl_q.converter_on) begin
      pdown_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_reset_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      timer1_reset_q <= special_event_trigger;
      wake_q <= done && sleep_mode && mask_q[EVT_DONE_BIT];
    end
  end

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  // A read clears only the bits it returned; later events survive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= EVT_RESET;
      mask_q <= EVT_RESET;
    end else begin
      status_q <= (status_q & ~((rd_acc && paddr == OFF_STATUS) ?
                  prdata_q[EVT_W-1:0] : EVT_RESET)) | {abort, done};
      if (wr_acc && paddr == OFF_MASK) begin
        mask_q <= pwdata[EVT_W-1:0];
      end
    end
  end

  // ************************************************************
  // APB slave, one wait state
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel && penable && !pready_q;
      if (psel && penable && !pready_q) begin
        pslverr_q <= !(paddr inside {OFF_CTRL, OFF_RES_HIGH, OFF_RES_LOW,
                                     OFF_STATUS, OFF_MASK});
        unique case (paddr)
          OFF_CTRL: prdata_q <= {26'h0, ctrl_q};
          OFF_RES_HIGH: prdata_q <= {24'h0, res_q.high};
          OFF_RES_LOW: prdata_q <= {24'h0, res_q.low};
          OFF_STATUS: prdata_q <= {30'h0, status_q};
          OFF_MASK: prdata_q <= {30'h0, mask_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign channel_select = ctrl_q.channel;
  assign converter_powered = ctrl_q.converter_on && !pdown_q;
  assign acquire = converter_powered && (state_q == ST_IDLE);
  assign timer1_reset = timer1_reset_q;
  assign wake_request = wake_q;
  assign irq = |(status_q & mask_q);

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_abort_seen;
    abort && ctrl_q.converter_on;
  endsequence
  sequence s_hold_quiet;
    !acquire [*2];
  endsequence
  property p_off_idle;
    !ctrl_q.converter_on |=> state_q == ST_IDLE && !ctrl_q.go;
  endproperty
  a_off_idle: assert property (p_off_idle)
    else $error("Converter left idle while switched off.");
  property p_sw_start;
    start_sw && !sleep_mode |=> ctrl_q.go && state_q != ST_IDLE;
  endproperty
  a_sw_start: assert property (p_sw_start)
    else $error("Go write did not start a conversion.");
  property p_done;
    done |=> !ctrl_q.go && status_q[EVT_DONE_BIT] &&
             res_q == justify($past(ctrl_q.result_justify_select),
                              $past(samp_q));
  endproperty
  a_done: assert property (p_done)
    else $error("Completion did not clear go, flag and load result.");
  property p_justify_zero;
    done && !ctrl_q.result_justify_select |=> res_q.high[7:2] == 6'h00;
  endproperty
  a_justify_zero: assert property (p_justify_zero)
    else $error("Right justified high byte has stray bits.");
  property p_abort_keep;
    s_abort_seen |=> $stable(res_q) && state_q == ST_HOLD;
  endproperty
  a_abort_keep: assert property (p_abort_keep)
    else $error("Abort changed result or skipped hold-off.");
  property p_hold;
    s_abort_seen |=> s_hold_quiet ##[1:HOLD_MAX] state_q == ST_IDLE;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Hold-off after abort wrong.");
  property p_rc_delay;
    start && ctrl_q.rc_clock_select && ctrl_q.converter_on
    |=> state_q == ST_DELAY;
  endproperty
  a_rc_delay: assert property (p_rc_delay)
    else $error("RC start was not delayed.");
  property p_wake;
    done && sleep_mode && mask_q[EVT_DONE_BIT] |=> wake_request;
  endproperty
  a_wake: assert property (p_wake)
    else $error("No wake after sleep conversion.");
  property p_sleep_pdown;
    done && sleep_mode && !mask_q[EVT_DONE_BIT]
    |=> !converter_powered && ctrl_q.converter_on;
  endproperty
  a_sleep_pdown: assert property (p_sleep_pdown)
    else $error("Masked sleep completion did not power down.");
  property p_sleep_abort;
    abort_sleep && !wr_ctrl |=> !converter_powered && ctrl_q.converter_on
                                && !ctrl_q.go;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort)
    else $error("Sleep did not abort a non-RC conversion.");
  property p_trigger;
    start_trig && !abort_sleep |=> ctrl_q.go && timer1_reset;
  endproperty
  a_trigger: assert property (p_trigger)
    else $error("Trigger did not set go and reset timer1.");

endmodule // acs_sequencer
